/* rtl/dpm_pclk_div.sv */
`timescale 1ns/100ps
`default_nettype none

module dpm_pclk_div (
    input  wire logic clk_sys,
    input  wire logic rst,
    output var  logic pclk_q
);

    logic [3:0] cnt_q;
    logic       wrap;

    assign wrap = (cnt_q == dpm_pkg::PCLK_HALF_PERIOD - 4'h1);

    // The divider never looks at power state, so the clock keeps toggling.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q  <= 4'h0;
            pclk_q <= 1'b0;
        end else begin
            cnt_q  <= wrap ? 4'h0 : cnt_q + 4'h1;
            pclk_q <= wrap ? ~pclk_q : pclk_q;
        end
    end

endmodule

`default_nettype wire

/* rtl/dpm_pkg.sv */
package dpm_pkg;

    // ==================================================================
    // Timing constants
    // ==================================================================
    // Cycles the datapath clear routine holds the path in reset.
    localparam int unsigned        CLEAR_CYCLES     = 16;
    // Flush time after the end of a burst before clocks stop.
    localparam int unsigned        FLUSH_CYCLES     = 32;
    localparam logic [7:0]         CNT_RESET        = 8'h00;
    // Parallel data clock runs at the system clock divided by twice this (it toggles every this many cycles).
    localparam logic [3:0]         PCLK_HALF_PERIOD = 4'h4;

    // ==================================================================
    // Control register bit positions within control register 01h
    // ==================================================================
    localparam int unsigned        CTRL01_AUTO_PD_BIT = 2;
    localparam int unsigned        CTRL01_SLEEP_BIT   = 3;
    localparam logic [7:0]         CTRL01_RESET       = 8'h00;

    typedef enum logic [5:0] {
        DPM_RUN      = 6'h01,
        DPM_CLEAR    = 6'h02,
        DPM_DPD      = 6'h04,
        DPM_FLUSH    = 6'h08,
        DPM_AUTO_OFF = 6'h10,
        DPM_SLEEP    = 6'h20
    } dpm_state_t;

    typedef struct packed {
        logic clk_en;
        logic path_zero;
        logic cic_reset;
        logic analog_off;
    } dpm_ctrl_t;

endpackage

/* rtl/dpm_power_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Digital power-down pin high enters digital power-down, stopping processing clocks.
// - Pin returning low leaves power-down and restarts processing clocks.
// - Pin release together with transmit enable starts the burst correctly.
// - Entering power-down first runs datapath clear, then gates clocks, except when sleep is left with the pin still high.
// - Auto mode: after burst end, a timer flushes the path before clocks stop.
// - Clock synchronisation and parallel data clock keep running in power-down.
// - Transmit enable high restarts auto-stopped clocks immediately.
// - Control bit 01h<2> enables or disables automatic burst power-down.
// - Control bit 01h<3> enters full sleep, digital and analog off.
// - Control registers keep their contents throughout full sleep.
// - Clear routine ignores samples, zeros I and Q, holds CIC in reset.
// - Setting sleep runs the clear routine to completion before powering down, except from digital power-down, which enters sleep directly.

module dpm_power_ctrl (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       digital_powerdown_pin,
    input  wire logic       transmit_frame_enable,
    input  wire logic       ctrl_wr,
    input  wire logic [7:0] ctrl_wdata,
    input  wire logic       pll_lock,
    output var  logic [7:0] ctrl01_q,
    output var  logic       proc_clk_en_q,
    output var  logic       path_zero_q,
    output var  logic       cic_reset_q,
    output var  logic       analog_off_q,
    output var  logic       tx_accept_q,
    output var  logic       ready_q,
    output var  logic       parallel_data_clock
);

    // ==================================================================
    // Control register
    // ==================================================================
    logic auto_pd;
    logic sleep_req;

    // Register is only changed by reset and by writes, so sleep leaves it intact.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl01_q <= dpm_pkg::CTRL01_RESET;
        end else if (ctrl_wr) begin
            ctrl01_q <= ctrl_wdata;
        end
    end

    assign auto_pd   = ctrl01_q[dpm_pkg::CTRL01_AUTO_PD_BIT];
    assign sleep_req = ctrl01_q[dpm_pkg::CTRL01_SLEEP_BIT];

    // ==================================================================
    // Power state machine
    // ==================================================================
    dpm_pkg::dpm_state_t state_q;
    dpm_pkg::dpm_state_t state_d;
    logic [7:0]          cnt_q;
    logic [7:0]          cnt_d;
    logic                clear_done;
    logic                flush_done;
    logic                down_req;
    logic                tx_q;
    logic                burst_end;

    assign down_req   = digital_powerdown_pin | sleep_req;
    assign clear_done = (cnt_q == 8'(dpm_pkg::CLEAR_CYCLES - 1));
    assign flush_done = (cnt_q == 8'(dpm_pkg::FLUSH_CYCLES - 1));
    assign burst_end  = tx_q & ~transmit_frame_enable;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 8'h01;
        unique case (state_q)
            dpm_pkg::DPM_RUN: begin
                cnt_d = dpm_pkg::CNT_RESET;
                if (down_req) begin
                    state_d = dpm_pkg::DPM_CLEAR;
                end else if (auto_pd && burst_end) begin
                    state_d = dpm_pkg::DPM_FLUSH;
                end
            end
            dpm_pkg::DPM_CLEAR: begin
                if (clear_done) begin
                    cnt_d   = dpm_pkg::CNT_RESET;
                    state_d = sleep_req ? dpm_pkg::DPM_SLEEP : dpm_pkg::DPM_DPD;
                end
            end
            dpm_pkg::DPM_DPD: begin
                cnt_d = dpm_pkg::CNT_RESET;
                if (sleep_req) begin
                    state_d = dpm_pkg::DPM_SLEEP;
                end else if (!digital_powerdown_pin) begin
                    state_d = dpm_pkg::DPM_RUN;
                end
            end
            dpm_pkg::DPM_FLUSH: begin
                if (down_req) begin
                    cnt_d   = dpm_pkg::CNT_RESET;
                    state_d = dpm_pkg::DPM_CLEAR;
                end else if (transmit_frame_enable || !auto_pd) begin
                    state_d = dpm_pkg::DPM_RUN;
                end else if (flush_done) begin
                    state_d = dpm_pkg::DPM_AUTO_OFF;
                end
            end
            dpm_pkg::DPM_AUTO_OFF: begin
                cnt_d = dpm_pkg::CNT_RESET;
                if (down_req) begin
                    state_d = dpm_pkg::DPM_CLEAR;
                end else if (transmit_frame_enable || !auto_pd) begin
                    state_d = dpm_pkg::DPM_RUN;
                end
            end
            dpm_pkg::DPM_SLEEP: begin
                cnt_d = dpm_pkg::CNT_RESET;
                if (!sleep_req) begin
                    state_d = digital_powerdown_pin ? dpm_pkg::DPM_DPD : dpm_pkg::DPM_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= dpm_pkg::DPM_RUN;
            cnt_q   <= dpm_pkg::CNT_RESET;
            tx_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            tx_q    <= transmit_frame_enable;
        end
    end

    // ==================================================================
    // Output decode
    // ==================================================================
    dpm_pkg::dpm_ctrl_t ctrl_d;
    logic               running_d;
    logic               in_clear_d;
    logic               in_sleep_d;

    assign running_d  = (state_d == dpm_pkg::DPM_RUN) || (state_d == dpm_pkg::DPM_FLUSH);
    assign in_clear_d = (state_d == dpm_pkg::DPM_CLEAR);
    assign in_sleep_d = (state_d == dpm_pkg::DPM_SLEEP);

    // Fields in carrier order: clock enable, path zero, CIC reset, analog off.
    assign ctrl_d = {running_d | in_clear_d,
                     in_clear_d,
                     in_clear_d,
                     in_sleep_d};

    // Outputs follow the next state, so a release with transmit enable
    // high already has clocks running in the cycle the burst starts.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            proc_clk_en_q <= 1'b1;
            path_zero_q   <= 1'b0;
            cic_reset_q   <= 1'b0;
            analog_off_q  <= 1'b0;
            tx_accept_q   <= 1'b0;
            ready_q       <= 1'b1;
        end else begin
            proc_clk_en_q <= ctrl_d.clk_en;
            path_zero_q   <= ctrl_d.path_zero;
            cic_reset_q   <= ctrl_d.cic_reset;
            analog_off_q  <= ctrl_d.analog_off;
            tx_accept_q   <= running_d & transmit_frame_enable;
            ready_q       <= running_d;
        end
    end

    // ==================================================================
    // Parallel data clock
    // ==================================================================
    dpm_pclk_div u_pclk (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pclk_q  (parallel_data_clock)
    );

    // ==================================================================
    // Checks
    // ==================================================================
    logic       pclk_prev_q;
    logic [4:0] still_q;
    logic [7:0] clear_len_q;

    // The edge history starts opposite to the divider's reset level, so the
    // restart after reset counts as an edge and the first half period is not
    // stretched by the reset cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pclk_prev_q <= 1'b1;
            still_q     <= 5'h00;
            clear_len_q <= 8'h00;
        end else begin
            pclk_prev_q <= parallel_data_clock;
            still_q     <= (parallel_data_clock != pclk_prev_q) ? 5'h00 : still_q + 5'h01;
            clear_len_q <= cic_reset_q ? clear_len_q + 8'h01 : 8'h00;
        end
    end

    a_pin_enters_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == dpm_pkg::DPM_RUN) && digital_powerdown_pin |=> state_q == dpm_pkg::DPM_CLEAR)
        else $error("power-down pin did not start the clear routine");

    a_pin_release_run: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == dpm_pkg::DPM_DPD) && !digital_powerdown_pin && !sleep_req
        |=> state_q == dpm_pkg::DPM_RUN ##0 proc_clk_en_q)
        else $error("clocks did not restart after pin release");

    a_release_with_tx: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == dpm_pkg::DPM_DPD) && !digital_powerdown_pin && !sleep_req && transmit_frame_enable
        |=> tx_accept_q)
        else $error("burst lost on simultaneous release");

    a_clear_before_gate: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(state_q == dpm_pkg::DPM_CLEAR) |-> (cic_reset_q && path_zero_q && proc_clk_en_q) [*8])
        else $error("clocks gated before clear finished");

    a_flush_timer: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(state_q == dpm_pkg::DPM_AUTO_OFF) |-> $past(cnt_q) == 8'(dpm_pkg::FLUSH_CYCLES - 1))
        else $error("clocks stopped before flush timer expired");

    a_pclk_toggles: assert property (@(posedge clk_sys) disable iff (rst)
        still_q < 5'(dpm_pkg::PCLK_HALF_PERIOD))
        else $error("parallel data clock stopped");

    a_tx_restarts: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == dpm_pkg::DPM_AUTO_OFF) && transmit_frame_enable && !down_req
        |=> proc_clk_en_q && state_q == dpm_pkg::DPM_RUN)
        else $error("transmit enable did not restart clocks");

    a_sleep_analog: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == dpm_pkg::DPM_SLEEP |-> analog_off_q && !proc_clk_en_q)
        else $error("sleep did not shut down sections");

    a_regs_kept: assert property (@(posedge clk_sys) disable iff (rst)
        analog_off_q && !ctrl_wr |=> $stable(ctrl01_q))
        else $error("control register lost in sleep");

    a_pin_holds_down: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == dpm_pkg::DPM_DPD) && digital_powerdown_pin |=> !proc_clk_en_q)
        else $error("device woke while pin high");

    // The clear strobes must stand for the whole routine, not merely start.
    a_clear_length: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(cic_reset_q)
        |-> clear_len_q == 8'(dpm_pkg::CLEAR_CYCLES))
        else $error("clear routine cut short");

    a_clear_zeros_path: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == dpm_pkg::DPM_CLEAR
        |-> path_zero_q && cic_reset_q)
        else $error("clear routine did not zero the path");

    a_no_stray_clear: assert property (@(posedge clk_sys) disable iff (rst)
        state_q != dpm_pkg::DPM_CLEAR
        |-> !path_zero_q && !cic_reset_q)
        else $error("path held clear outside the routine");

    a_sleep_after_clear: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(state_q == dpm_pkg::DPM_SLEEP)
        |-> ($past(state_q) == dpm_pkg::DPM_CLEAR) || ($past(state_q) == dpm_pkg::DPM_DPD))
        else $error("sleep entered without a cleared path");

    a_dpd_clocks_off: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == dpm_pkg::DPM_DPD
        |-> !proc_clk_en_q && !ready_q)
        else $error("clocks running in power-down");

    a_run_clocks_on: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == dpm_pkg::DPM_RUN
        |-> proc_clk_en_q && ready_q)
        else $error("clocks stopped while running");

    a_flush_keeps_run: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == dpm_pkg::DPM_FLUSH
        |-> proc_clk_en_q && ready_q)
        else $error("clocks stopped during flush");

    a_auto_off_gated: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == dpm_pkg::DPM_AUTO_OFF
        |-> !proc_clk_en_q)
        else $error("clocks running after automatic stop");

    a_burst_end_flush: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == dpm_pkg::DPM_RUN) && auto_pd && burst_end && !down_req
        |=> state_q == dpm_pkg::DPM_FLUSH)
        else $error("burst end did not start the flush timer");

    a_auto_bit_off: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == dpm_pkg::DPM_RUN) && !auto_pd && !down_req
        |=> state_q == dpm_pkg::DPM_RUN)
        else $error("automatic stop ran while disabled");

    a_ctrl_write: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_wr
        |=> ctrl01_q == $past(ctrl_wdata))
        else $error("control write not taken");

    a_sleep_wakes: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == dpm_pkg::DPM_SLEEP) && !sleep_req && !digital_powerdown_pin
        |=> state_q == dpm_pkg::DPM_RUN ##0 !analog_off_q)
        else $error("device did not wake from sleep");

    a_tx_refused_down: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == dpm_pkg::DPM_DPD) || (state_q == dpm_pkg::DPM_CLEAR) || (state_q == dpm_pkg::DPM_SLEEP)
        |-> !tx_accept_q)
        else $error("burst accepted while powered down");

endmodule

`default_nettype wire

/* verification/digital_power_management_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module digital_power_management_tb;
    logic            clk_sys = 1'b0;
    logic            rst     = 1'b1;
    wire logic       pin, tx, wr, pll, clk_en, pzero, cicr, aoff, txacc, rdy, pdc;
    wire logic [7:0] wdata, ctrl;
    int              error_cnt   = 0;
    int              comparisons = 0;

    always #5 clk_sys = ~clk_sys;

    dpm_host_model host_u (.clk_sys(clk_sys), .analog_off_q(aoff), .digital_powerdown_pin(pin),
        .transmit_frame_enable(tx), .ctrl_wr(wr), .ctrl_wdata(wdata), .pll_lock(pll));

    dpm_power_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .digital_powerdown_pin(pin),
        .transmit_frame_enable(tx), .ctrl_wr(wr), .ctrl_wdata(wdata), .pll_lock(pll),
        .ctrl01_q(ctrl), .proc_clk_en_q(clk_en), .path_zero_q(pzero), .cic_reset_q(cicr),
        .analog_off_q(aoff), .tx_accept_q(txacc), .ready_q(rdy), .parallel_data_clock(pdc));

    // ==================================================================
    // Shared tasks
    // ==================================================================
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
            error_cnt++;
        end
    endtask

    // Counts clear cycles, running cycles and parallel clock changes over a window.
    task automatic watch(input int cycles, output int nz, output int nrun, output int ntog);
        logic prev;
        nz   = 0;
        nrun = 0;
        ntog = 0;
        prev = pdc;
        repeat (cycles) begin
            @(posedge clk_sys);
            #1;
            nz   += int'(pzero === 1'b1 && cicr === 1'b1);
            nrun += int'(clk_en === 1'b1);
            ntog += int'(pdc !== prev);
            prev = pdc;
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==================================================================
    // Scenarios
    // ==================================================================
    task automatic t_pin_down;
        int nz, nrun, ntog;
        host_u.drive(1'b1, 1'b0);
        watch(40, nz, nrun, ntog);
        chk("clear_cycles", dpm_pkg::CLEAR_CYCLES, nz);
        chk("run_cycles", dpm_pkg::CLEAR_CYCLES, nrun);
        chk("pclk_toggles", 10, ntog);
        chk("ready_down", 1'b0, rdy);
        host_u.write_ctrl(8'h04);
        host_u.drive(1'b1, 1'b1);
        watch(8, nz, nrun, ntog);
        chk("run_auto", 0, nrun);
        chk("tx_accept", 1'b0, txacc);
        host_u.drive(1'b1, 1'b0);
        host_u.drive(1'b0, 1'b1);
        @(posedge clk_sys);
        #1;
        chk("clk_en_up", 1'b1, clk_en);
        chk("ready_up", 1'b1, rdy);
        chk("burst_taken", 1'b1, txacc);
        $display("test pin_down done");
    endtask

    task automatic t_auto;
        int nz, nrun, ntog;
        chk("ctrl01_auto", 8'h04, ctrl);
        host_u.drive(1'b0, 1'b0);
        watch(40, nz, nrun, ntog);
        chk("flush_cycles", dpm_pkg::FLUSH_CYCLES, nrun);
        chk("flush_clear", 0, nz);
        chk("pclk_auto", 10, ntog);
        chk("auto_ready", 1'b0, rdy);
        host_u.drive(1'b0, 1'b1);
        @(posedge clk_sys);
        #1;
        chk("restart", 1'b1, clk_en);
        chk("restart_tx", 1'b1, txacc);
        host_u.write_ctrl(8'h00);
        chk("ctrl01_off", 8'h00, ctrl);
        host_u.drive(1'b0, 1'b0);
        watch(40, nz, nrun, ntog);
        chk("no_auto_stop", 40, nrun);
        $display("test auto done");
    endtask

    task automatic t_sleep;
        int nz, nrun, ntog;
        logic locked;
        host_u.write_ctrl(8'h08);
        watch(40, nz, nrun, ntog);
        chk("sleep_clear", dpm_pkg::CLEAR_CYCLES, nz);
        chk("sleep_analog", 1'b1, aoff);
        chk("sleep_clk", 1'b0, clk_en);
        chk("sleep_ctrl01", 8'h08, ctrl);
        host_u.wake(locked);
        chk("locked", 1'b1, locked);
        chk("wake_analog", 1'b0, aoff);
        chk("wake_clk", 1'b1, clk_en);
        host_u.drive(1'b0, 1'b1);
        @(posedge clk_sys);
        #1;
        chk("wake_burst", 1'b1, txacc);
        host_u.drive(1'b0, 1'b0);
        $display("test sleep done");
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk("reset_ctrl01", dpm_pkg::CTRL01_RESET, ctrl);
        chk("reset_ready", 1'b1, rdy);
        $display("test reset done");
        t_pin_down();
        t_auto();
        t_sleep();
        wrap_up();
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        wrap_up();
    end
endmodule

`default_nettype wire

/* verification/dpm_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ==================================================================
// Host controller model
// ==================================================================
module dpm_host_model #(
    parameter int LOCK_DELAY = 20
) (
    input  wire logic       clk_sys,
    input  wire logic       analog_off_q,
    output var  logic       digital_powerdown_pin,
    output var  logic       transmit_frame_enable,
    output var  logic       ctrl_wr,
    output var  logic [7:0] ctrl_wdata,
    output wire logic       pll_lock
);
    int lock_cnt = 0;

    initial begin
        digital_powerdown_pin = 1'b0;
        transmit_frame_enable = 1'b0;
        ctrl_wr               = 1'b0;
        ctrl_wdata            = 8'h5a;
    end

    // The lock flag drops in full sleep and comes back some cycles after waking.
    always @(posedge clk_sys) begin
        if (analog_off_q === 1'b1) begin
            lock_cnt <= LOCK_DELAY;
        end else if (lock_cnt > 0) begin
            lock_cnt <= lock_cnt - 1;
        end
    end
    assign pll_lock = (lock_cnt == 0) && (analog_off_q !== 1'b1);

    // Both pins may change in the same cycle.
    task automatic drive(input logic pin, input logic tx);
        @(negedge clk_sys);
        digital_powerdown_pin = pin;
        transmit_frame_enable = tx;
    endtask

    task automatic write_ctrl(input logic [7:0] data);
        @(negedge clk_sys);
        ctrl_wr    = 1'b1;
        ctrl_wdata = data;
        @(negedge clk_sys);
        ctrl_wr    = 1'b0;
        ctrl_wdata = ~data;
    endtask

    // Leaves full sleep and holds off until the lock flag is high, giving up after 4 * LOCK_DELAY cycles.
    task automatic wake(output logic locked);
        write_ctrl(8'h00);
        locked = 1'b0;
        for (int i = 0; i < 4 * LOCK_DELAY; i++) begin
            @(negedge clk_sys);
            if (pll_lock === 1'b1) begin
                locked = 1'b1;
                break;
            end
        end
    endtask
endmodule

`default_nettype wire
